// ### design/fast_role_swap_signaling.v
// fast role swap signaling: transmit pulse on cc, cc and vbus detection, avalon-mm registers
// assumes all inputs synchronous to mclk and a 250 mhz mclk
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps
`include "swap_defs.vh"
module fast_role_swap_signaling (
  mclk,
  rst_n,
  clk_en,
  avs_address,
  avs_read,
  avs_write,
  avs_writedata,
  avs_byteenable,
  avs_readdata,
  avs_waitrequest,
  pio_in,
  cc_below_threshold,
  vbus_low,
  threshold_select,
  cc1_drive_low,
  cc2_drive_low,
  mac_disconnect_override,
  irq
);
  input              mclk;
  input              rst_n;
  input              clk_en;
  input  [11:0]      avs_address;
  input              avs_read;
  input              avs_write;
  input  [31:0]      avs_writedata;
  input  [3:0]       avs_byteenable;
  output [31:0]      avs_readdata;
  output             avs_waitrequest;
  input  [15:0]      pio_in;
  input              cc_below_threshold;
  input              vbus_low;
  output [2:0]       threshold_select;
  output             cc1_drive_low;
  output             cc2_drive_low;
  output             mac_disconnect_override;
  output             irq;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  reg    [15:0]      ctl_q;
  reg    [7:0]       cc_deb_q;
  reg    [7:0]       tx_len_q;
  reg    [2:0]       thr_sel_q;
  reg    [3:0]       pio_sel_q;
  reg    [3:0]       vbus_deb_q;
  reg    [15:0]      sample_div_q;
  reg    [`IRQ_WIDTH-1:0] irq_status_q;
  reg    [`IRQ_WIDTH-1:0] irq_enable_q;
  reg    [31:0]      readdata_q;
  reg                ack_q;
  reg                cc1_q;
  reg                cc2_q;

  wire               access;
  wire               accept;
  wire               wr;
  wire   [15:0]      wmask;
  wire   [15:0]      wdata;

  assign access          = (avs_read | avs_write) & ~ack_q;
  // a transfer completes, and a write lands, only on the edge that sees waitrequest low
  assign accept          = (avs_read | avs_write) & ack_q & clk_en;
  assign avs_waitrequest = (avs_read | avs_write) & ~accept;
  assign avs_readdata    = readdata_q;
  assign wr              = avs_write & accept;
  assign wmask           = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wdata           = avs_writedata[15:0];

  ////////////////////////////////////////////////////////////////////////////
  // sample tick generator
  reg    [15:0]      div_cnt_q;
  reg                sample_tick_q;

  always @(posedge mclk) begin
    if (!rst_n) begin
      div_cnt_q     <= 16'h0000;
      sample_tick_q <= 1'b0;
    end else if (clk_en) begin
      if (div_cnt_q >= sample_div_q) begin
        div_cnt_q     <= 16'h0000;
        sample_tick_q <= 1'b1;
      end else begin
        div_cnt_q     <= div_cnt_q + 16'h0001;
        sample_tick_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit state machine
  localparam ST_IDLE = 2'b00;
  localparam ST_SEND = 2'b01;
  localparam ST_DONE = 2'b10;

  reg    [1:0]       state_q;
  reg    [7:0]       us_left_q;
  reg    [7:0]       us_cnt_q;
  reg                pio_prev_q;
  wire               pio_level;
  wire               pio_hit;
  wire               start_req;
  wire               tx_done;

  // pio trigger fires on entry into the selected level, so a held level sends once
  assign pio_level = pio_in[pio_sel_q] == ctl_q[`CTL_PIO_LVL_BIT];
  assign pio_hit   = ctl_q[`CTL_PIO_EN_BIT] & pio_level & ~pio_prev_q;
  assign start_req = ctl_q[`CTL_REQ_BIT] | pio_hit;
  assign tx_done   = (state_q == ST_DONE);

  always @(posedge mclk) begin
    if (!rst_n) begin
      state_q    <= ST_IDLE;
      us_left_q  <= 8'h00;
      us_cnt_q   <= 8'h00;
      pio_prev_q <= 1'b0;
      cc1_q      <= 1'b0;
      cc2_q      <= 1'b0;
    end else if (clk_en) begin
      pio_prev_q <= ctl_q[`CTL_PIO_EN_BIT] & pio_level;
      case (state_q)
        ST_IDLE: begin
          if (start_req && tx_len_q != 8'h00) begin
            state_q   <= ST_SEND;
            us_left_q <= tx_len_q;
            us_cnt_q  <= 8'h00;
            cc1_q     <= ~ctl_q[`CTL_CC_SEL_HI] & ~ctl_q[`CTL_CC_SEL_LO] | ctl_q[`CTL_CC_SEL_HI];
            cc2_q     <= ctl_q[`CTL_CC_SEL_LO] | ctl_q[`CTL_CC_SEL_HI];
          end else if (start_req) begin
            state_q <= ST_DONE;
          end
        end
        ST_SEND: begin
          if (us_cnt_q == `US_CNT_LAST) begin
            us_cnt_q <= 8'h00;
            if (us_left_q == 8'h01) begin
              state_q <= ST_DONE;
              cc1_q   <= 1'b0;
              cc2_q   <= 1'b0;
            end else begin
              us_left_q <= us_left_q - 8'h01;
            end
          end else begin
            us_cnt_q <= us_cnt_q + 8'h01;
          end
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign cc1_drive_low = cc1_q;
  assign cc2_drive_low = cc2_q;

  ////////////////////////////////////////////////////////////////////////////
  // detection
  wire               cc_det;
  wire               vbus_det;
  reg                cc_det_prev_q;
  reg                vbus_det_prev_q;
  wire               cc_det_rise;
  wire               vbus_det_rise;

  debounce_counter #(.W(8)) u_cc_deb (
    .mclk        (mclk),
    .rst_n       (rst_n),
    .clk_en      (clk_en),
    .enable      (ctl_q[`CTL_DET_BIT]),
    .sample_tick (sample_tick_q),
    .level_low   (cc_below_threshold),
    .period      (cc_deb_q),
    .detected    (cc_det)
  );

  debounce_counter #(.W(4)) u_vbus_deb (
    .mclk        (mclk),
    .rst_n       (rst_n),
    .clk_en      (clk_en),
    .enable      (ctl_q[`CTL_DET_BIT]),
    .sample_tick (sample_tick_q),
    .level_low   (vbus_low),
    .period      (vbus_deb_q),
    .detected    (vbus_det)
  );

  assign cc_det_rise   = cc_det & ~cc_det_prev_q;
  assign vbus_det_rise = vbus_det & ~vbus_det_prev_q;

  always @(posedge mclk) begin
    if (!rst_n) begin
      cc_det_prev_q   <= 1'b0;
      vbus_det_prev_q <= 1'b0;
    end else if (clk_en) begin
      cc_det_prev_q   <= cc_det;
      vbus_det_prev_q <= vbus_det;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes, sticky override and interrupt status
  wire   [`IRQ_WIDTH-1:0] irq_events;
  wire   [15:0]      ctl_w;

  assign irq_events = {vbus_det_rise, cc_det_rise, tx_done};
  assign ctl_w      = (ctl_q & ~(wmask & `CTL_WR_MASK)) | (wdata & wmask & `CTL_WR_MASK);

  always @(posedge mclk) begin
    if (!rst_n) begin
      ctl_q        <= `CTL_RESET;
      cc_deb_q     <= 8'h00;
      tx_len_q     <= 8'h00;
      thr_sel_q    <= 3'h0;
      pio_sel_q    <= 4'h0;
      vbus_deb_q   <= 4'h0;
      sample_div_q <= `SAMPLE_DIV_RESET;
      irq_status_q <= {`IRQ_WIDTH{1'b0}};
      irq_enable_q <= {`IRQ_WIDTH{1'b0}};
    end else if (clk_en) begin
      if (wr && avs_address == `IDX_CTL) begin
        ctl_q[14:0] <= ctl_w[14:0];
        if (avs_byteenable[1] && wdata[`CTL_REQ_BIT]) begin
          ctl_q[`CTL_REQ_BIT] <= 1'b1;
        end else begin
          ctl_q[`CTL_REQ_BIT] <= 1'b0;
        end
      // a request made during a pulse stays pending until the sender is idle
      end else if (start_req && state_q == ST_IDLE) begin
        ctl_q[`CTL_REQ_BIT] <= 1'b0;
      end
      // hardware set wins over a firmware clear
      if (tx_done || cc_det_rise) begin
        ctl_q[`CTL_OVR_BIT] <= 1'b1;
      end
      if (wr && avs_address == `IDX_CC_DEB && avs_byteenable[0]) begin
        cc_deb_q <= wdata[7:0];
      end
      if (wr && avs_address == `IDX_TX_LEN && avs_byteenable[0]) begin
        tx_len_q <= wdata[7:0];
      end
      if (wr && avs_address == `IDX_THR_SEL && avs_byteenable[0]) begin
        thr_sel_q <= wdata[2:0];
      end
      if (wr && avs_address == `IDX_PIO_SEL && avs_byteenable[0]) begin
        pio_sel_q <= wdata[`PIO_SEL_HI:`PIO_SEL_LO];
      end
      if (wr && avs_address == `IDX_VBUS_DEB && avs_byteenable[0]) begin
        vbus_deb_q <= wdata[3:0];
      end
      if (wr && avs_address == `IDX_SAMPLE_DIV) begin
        sample_div_q <= (sample_div_q & ~wmask) | (wdata & wmask);
      end
      if (wr && avs_address == `IDX_IRQ_ENABLE && avs_byteenable[0]) begin
        irq_enable_q <= wdata[`IRQ_WIDTH-1:0];
      end
      // a clear that meets a new event leaves the event set
      if (wr && avs_address == `IDX_IRQ_CLEAR && avs_byteenable[0]) begin
        irq_status_q <= (irq_status_q & ~wdata[`IRQ_WIDTH-1:0]) | irq_events;
      end else begin
        irq_status_q <= irq_status_q | irq_events;
      end
    end
  end

  assign threshold_select        = thr_sel_q;
  assign mac_disconnect_override = ctl_q[`CTL_OVR_BIT];
  assign irq                     = |(irq_status_q & irq_enable_q);

  ////////////////////////////////////////////////////////////////////////////
  // read path: data loaded on the first edge, taken by the master on the second
  always @(posedge mclk) begin
    if (!rst_n) begin
      ack_q      <= 1'b0;
      readdata_q <= 32'h00000000;
    end else if (clk_en) begin
      ack_q <= access;
      if (access && avs_read) begin
        case (avs_address)
          `IDX_CTL:        readdata_q <= {16'h0000, ctl_q & 16'hf130};
          `IDX_CC_DEB:     readdata_q <= {24'h000000, cc_deb_q};
          `IDX_TX_LEN:     readdata_q <= {24'h000000, tx_len_q};
          `IDX_THR_SEL:    readdata_q <= {29'h00000000, thr_sel_q};
          `IDX_PIO_SEL:    readdata_q <= {24'h000000, pio_sel_q, 4'h0};
          `IDX_VBUS_DEB:   readdata_q <= {28'h0000000, vbus_deb_q};
          `IDX_SAMPLE_DIV: readdata_q <= {16'h0000, sample_div_q};
          `IDX_IRQ_STATUS: readdata_q <= {29'h00000000, irq_status_q};
          `IDX_IRQ_ENABLE: readdata_q <= {29'h00000000, irq_enable_q};
          default:         readdata_q <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // fast_role_swap_signaling

// ### design/swap_defs.vh
// constants for the fast role swap signaling block
// assumes an Avalon-MM slave with 32-bit data, word addresses = index, byte address = 4 * index
`ifndef SWAP_DEFS_VH
`define SWAP_DEFS_VH

// printed offsets are register indices; byte address is four times the index
`define IDX_CTL          12'h8a0
`define IDX_CC_DEB       12'h8a2
`define IDX_TX_LEN       12'h8a4
`define IDX_THR_SEL      12'h8a6
`define IDX_PIO_SEL      12'h8a7
`define IDX_VBUS_DEB     12'h8a8
`define IDX_IRQ_STATUS   12'h8c0
`define IDX_IRQ_ENABLE   12'h8c1
`define IDX_IRQ_CLEAR    12'h8c2
`define IDX_SAMPLE_DIV   12'h8c3

// control register fields
`define CTL_REQ_BIT      15
`define CTL_DET_BIT      14
`define CTL_PIO_EN_BIT   13
`define CTL_PIO_LVL_BIT  12
`define CTL_OVR_BIT      8
`define CTL_CC_SEL_HI    5
`define CTL_CC_SEL_LO    4
`define CTL_RESET        16'h1000
`define CTL_WR_MASK      16'h7130
`define PIO_SEL_HI       7
`define PIO_SEL_LO       4

// interrupt status bits
`define IRQ_TX_DONE      0
`define IRQ_DETECT       1
`define IRQ_VBUS         2
`define IRQ_WIDTH        3

// timing
`define CLK_MHZ          250
`define US_CYCLES        (`CLK_MHZ)
// last mclk count inside one microsecond, US_CYCLES - 1
`define US_CNT_LAST      8'hf9
`define SAMPLE_DIV_RESET 16'h03e7

`endif

// ### design/debounce_counter.v
// low-level debouncer counting in units of two sample ticks
// assumes sample_tick is a one-cycle strobe in the mclk domain
`timescale 1ns/1ps
module debounce_counter #(
  parameter W = 8
) (
  mclk,
  rst_n,
  clk_en,
  enable,
  sample_tick,
  level_low,
  period,
  detected
);
  input              mclk;
  input              rst_n;
  input              clk_en;
  input              enable;
  input              sample_tick;
  input              level_low;
  input  [W-1:0]     period;
  output             detected;

  reg    [W:0]       count_q;
  reg                detected_q;
  wire   [W:0]       target;

  // two sample ticks per count
  assign target   = {period, 1'b0};
  assign detected = detected_q;

  always @(posedge mclk) begin
    if (!rst_n) begin
      count_q    <= {(W+1){1'b0}};
      detected_q <= 1'b0;
    end else if (clk_en) begin
      if (!enable || !level_low) begin
        count_q    <= {(W+1){1'b0}};
        detected_q <= 1'b0;
      end else if (sample_tick) begin
        if (count_q >= target) begin
          detected_q <= 1'b1;
        end else begin
          count_q <= count_q + {{W{1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // debounce_counter

// ### tb/swap_chk.sv
// port checker for fast_role_swap_signaling
// assumes one mclk domain and synchronous active-low reset
`timescale 1ns/1ps
module swap_chk (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        avs_write,
  input wire logic [15:0] pio_in,
  input wire logic        cc_below_threshold,
  input wire logic [2:0]  threshold_select,
  input wire logic        cc1_drive_low,
  input wire logic        cc2_drive_low,
  input wire logic        mac_disconnect_override
);
  logic [15:0] dcnt_q;
  wire         drv = cc1_drive_low | cc2_drive_low;
  // length of the current drive pulse in mclk cycles
  always @(posedge mclk) begin
    dcnt_q <= drv ? dcnt_q + 16'h0001 : 16'h0000;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence drv_start; $rose(drv); endsequence
  sequence drv_end; $fell(drv); endsequence
  drive_hold_a: assert property (drv_start |-> drv [*8])
    else $error("cc drive pulse too short");
  drive_len_a: assert property (drv_end |-> (dcnt_q % 16'h00fa) == 16'h0000)
    else $error("cc drive not whole microseconds");
  ovr_after_tx_a: assert property (drv_end |-> ##[0:2] mac_disconnect_override)
    else $error("override not set after send");
  ovr_sticky_a: assert property (mac_disconnect_override && !avs_write |=> mac_disconnect_override)
    else $error("override dropped without write");
  ovr_cause_a: assert property ($rose(mac_disconnect_override) |-> $past(avs_write) || $past(avs_write, 2)
    || $past(avs_write, 3) || $past(drv, 2) || $past(cc_below_threshold, 2) || $past(cc_below_threshold, 3))
    else $error("override set without cause");
  thr_follow_a: assert property (!$stable(threshold_select) |-> $past(avs_write) || $past(avs_write, 2))
    else $error("threshold select moved without write");
  both_pins_a: assert property (cc1_drive_low && cc2_drive_low |=> cc1_drive_low == cc2_drive_low)
    else $error("cc pins split while both driven");
  drive_start_a: assert property (drv_start |-> $past(avs_write, 2) || $past(avs_write, 3)
    || $past(pio_in) != $past(pio_in, 2) || $past(pio_in, 2) != $past(pio_in, 3))
    else $error("drive started without request");
endmodule // swap_chk
bind fast_role_swap_signaling swap_chk u_chk (.mclk(mclk), .rst_n(rst_n), .avs_write(avs_write),
  .pio_in(pio_in), .cc_below_threshold(cc_below_threshold), .threshold_select(threshold_select),
  .cc1_drive_low(cc1_drive_low), .cc2_drive_low(cc2_drive_low),
  .mac_disconnect_override(mac_disconnect_override));

// ### tb/remote_port_model.sv
// far port on cc: sends swap pulses and measures ours
// assumes mclk domain; start is a one-cycle command
`timescale 1ns/1ps
module remote_port_model (
  input  wire logic        mclk,
  input  wire logic        start,
  input  wire logic [15:0] send_len,
  input  wire logic        cc1_drive_low,
  input  wire logic        cc2_drive_low,
  output logic             cc_below_threshold,
  output logic [15:0]      seen_len,
  output logic [1:0]       seen_pins
);
  logic [15:0] left_q = 16'h0000;
  logic        drv_q = 1'b0;
  wire         drv = cc1_drive_low | cc2_drive_low;
  // cc is low while either end pulls it down
  assign cc_below_threshold = drv | (left_q != 16'h0000);
  initial begin
    seen_len = 16'h0000;
    seen_pins = 2'h0;
  end
  always @(posedge mclk) begin
    if (start) left_q <= send_len;
    else if (left_q != 16'h0000) left_q <= left_q - 16'h0001;
    drv_q <= drv;
    if (drv && !drv_q) begin
      seen_len <= 16'h0001;
      seen_pins <= {cc2_drive_low, cc1_drive_low};
    end else if (drv) begin
      seen_len <= seen_len + 16'h0001;
      seen_pins <= seen_pins | {cc2_drive_low, cc1_drive_low};
    end
  end
endmodule // remote_port_model

// ### tb/fast_role_swap_signaling_bench.sv
// self-checking bench for fast_role_swap_signaling
// assumes a 250 mhz mclk and the remote port model on cc
`timescale 1ns/1ps
module fast_role_swap_signaling_bench;
  logic        mclk, rst_n, avs_read, avs_write, start, vbus_low, avs_waitrequest, cc_below_threshold;
  logic        cc1_drive_low, cc2_drive_low, mac_disconnect_override, irq, clk_en;
  logic [11:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [15:0] pio_in, send_len, seen_len;
  logic [2:0]  threshold_select;
  logic [1:0]  seen_pins;
  int          mismatches = 0, n_tests = 0, cyc = 0;
  localparam logic [11:0] ra[8] = '{12'h8a2, 12'h8a4, 12'h8a6, 12'h8a7, 12'h8a8, 12'h8c3, 12'h8a1, 12'h8a0};
  localparam logic [15:0] rv[8] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h03e7, 16'h0, 16'h1000};
  localparam logic [15:0] wv[8] = '{16'hff, 16'hff, 16'hffff, 16'hffff, 16'hffff, 16'h3, 16'hffff, 16'h7fff};
  localparam logic [15:0] ev[8] = '{16'hff, 16'hff, 16'h7, 16'hf0, 16'hf, 16'h3, 16'h0, 16'h7130};
  fast_role_swap_signaling u_dut (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h3),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pio_in(pio_in),
    .cc_below_threshold(cc_below_threshold), .vbus_low(vbus_low), .threshold_select(threshold_select),
    .cc1_drive_low(cc1_drive_low), .cc2_drive_low(cc2_drive_low),
    .mac_disconnect_override(mac_disconnect_override), .irq(irq));
  remote_port_model u_far (.mclk(mclk), .start(start), .send_len(send_len), .cc1_drive_low(cc1_drive_low),
    .cc2_drive_low(cc2_drive_low), .cc_below_threshold(cc_below_threshold), .seen_len(seen_len),
    .seen_pins(seen_pins));
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // waitrequest is sampled at each rising edge; return on the edge that sees it low
  task automatic ack;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_write <= 1'b1;
    ack();
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [11:0] a, output logic [15:0] d);
    avs_address <= a;
    avs_read <= 1'b1;
    ack();
    d = avs_readdata[15:0];
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wait_ovr(input int lim, output int n);
    n = 0;
    while (mac_disconnect_override !== 1'b1 && n < lim) begin
      @(negedge mclk);
      n++;
    end
    chk(n < lim, 1'b1);
    @(posedge mclk);
  endtask
  task automatic send(input logic [15:0] len);
    send_len <= len;
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
  endtask
  ////////////////////////////////////////
  task automatic t_regs;
    logic [15:0] d;
    for (int i = 0; i < 8; i++) begin
      rd(ra[i], d);
      chk(d, rv[i]);
      wr(ra[i], wv[i]);
      rd(ra[i], d);
      chk(d, ev[i]);
    end
    chk(threshold_select, 3'h7);
    wr(12'h8a0, 16'h1000);
    $display("register test done");
  endtask
  task automatic t_hold;
    logic [15:0] d;
    int c0;
    c0 = cyc;
    fork
      wr(12'h8a4, 16'h0042);
      begin
        clk_en <= 1'b0;
        repeat (5) @(posedge mclk);
        clk_en <= 1'b1;
      end
    join
    chk(cyc - c0 >= 6, 1'b1);
    rd(12'h8a4, d);
    chk(d, 16'h0042);
    $display("clock enable test done");
  endtask
  task automatic t_tx;
    int n;
    wr(12'h8a4, 16'h003c);
    wr(12'h8c1, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      wr(12'h8a0, 16'h1000 + 16'(i * 16));
      wr(12'h8a0, 16'h9000 + 16'(i * 16));
      wait_ovr(16000, n);
      chk(seen_len, 16'h3a98);
      chk(seen_pins, {i != 0, i != 1});
      chk(irq, 1'b1);
      wr(12'h8c2, 16'h0001);
    end
    wr(12'h8a0, 16'h1000);
    chk(mac_disconnect_override, 1'b0);
    $display("transmit test done");
  endtask
  task automatic t_pio;
    int n;
    wr(12'h8a7, 16'h0050);
    wr(12'h8a0, 16'h3000);
    pio_in <= 16'h0010;
    repeat (30) @(negedge mclk);
    chk(cc1_drive_low, 1'b0);
    @(posedge mclk);
    pio_in <= 16'h0030;
    wait_ovr(16000, n);
    chk(seen_len, 16'h3a98);
    pio_in <= 16'h0000;
    wr(12'h8a0, 16'h1000);
    $display("pio test done");
  endtask
  task automatic t_detect;
    int n;
    wr(12'h8c3, 16'h0003);
    wr(12'h8a2, 16'h0005);
    wr(12'h8c1, 16'h0002);
    wr(12'h8a0, 16'h5000);
    send(16'h0014);
    repeat (40) @(negedge mclk);
    chk(mac_disconnect_override, 1'b0);
    @(posedge mclk);
    send(16'h0190);
    wait_ovr(200, n);
    chk(n >= 32 && n <= 52, 1'b1);
    chk(irq, 1'b1);
    wr(12'h8a0, 16'h1000);
    wr(12'h8c1, 16'h0000);
    chk(irq, 1'b0);
    wr(12'h8c1, 16'h0002);
    wr(12'h8c0, 16'h0000);
    chk(irq, 1'b1);
    wr(12'h8c2, 16'h0002);
    chk(irq, 1'b0);
    repeat (400) @(posedge mclk);
    $display("detect test done");
  endtask
  task automatic t_vbus;
    logic [15:0] s;
    wr(12'h8a8, 16'h0003);
    wr(12'h8a0, 16'h5000);
    vbus_low <= 1'b1;
    repeat (8) @(posedge mclk);
    rd(12'h8c0, s);
    chk(s & 16'h0004, 16'h0000);
    repeat (48) @(posedge mclk);
    rd(12'h8c0, s);
    chk(s & 16'h0004, 16'h0004);
    vbus_low <= 1'b0;
    wr(12'h8a0, 16'h1000);
    $display("vbus test done");
  endtask
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 90000) begin
      mismatches++;
      results();
    end
  end
  initial begin
    {rst_n, avs_read, avs_write, start, vbus_low} = 5'h00;
    clk_en = 1'b1;
    {avs_address, avs_writedata, pio_in, send_len} = 76'h0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_regs();
    t_hold();
    t_tx();
    t_pio();
    t_detect();
    t_vbus();
    results();
  end
endmodule // fast_role_swap_signaling_bench
